// ---- logic/cfwm_top.v ----
// Fault and warning manager for a two-channel power supply manager
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "cfwm_defs.vh"

module cfwm_top (
    input  wire        mclk,
    input  wire        reset,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // ADC results, same clock
    input  wire        adc_valid,
    input  wire        adc_chan,
    input  wire        adc_is_current,
    input  wire [15:0] adc_data,
    // Supervisor fault events and output good levels, same clock
    input  wire [1:0]  ov_fault_evt,
    input  wire [1:0]  uv_fault_evt,
    input  wire [1:0]  output_good,
    input  wire        vin_on,
    // Pins
    input  wire        share_clk_in,
    input  wire        watchdog_reset_in_n,
    input  wire [1:0]  shared_fault_line_n_in,
    output wire [1:0]  shared_fault_line_n_out,
    output reg  [1:0]  shared_fault_line_n_oe,
    output wire        aux_fault_out_n_out,
    output reg         aux_fault_out_n_oe,
    output wire        alert_out_n_out,
    output reg         alert_out_n_oe,
    output reg  [1:0]  converter_enable_out,
    output reg         power_good_out,
    output reg  [1:0]  dac_gain_high,
    output wire        irq,
    output wire        por_active
);
    reg  [7:0]  ctrl_r;
    reg  [15:0] ov_lim_r [0:1];
    reg  [15:0] uv_lim_r [0:1];
    reg  [15:0] oc_lim_r [0:1];
    reg  [3:0]  fault_line_propagate_sel;
    reg  [3:0]  fault_line_response_sel;
    reg  [3:0]  aux_fault_config_a;
    reg  [3:0]  aux_fault_config_b;
    reg  [1:0]  power_good_map;
    reg  [15:0] status_r;
    reg  [15:0] status_nxt;
    reg  [15:0] mask_r;
    reg  [1:0]  faulted_off_r;
    reg  [1:0]  aux_latch_r;
    reg  [1:0]  line_off_r;
    reg  [1:0]  line_off_nxt;
    reg  [1:0]  on_cmd_d_r;
    reg         seq_on_r;
    reg         share_d_r;
    reg  [15:0] set_vec;
    reg  [31:0] rd_nxt;
    wire [1:0]  line_low;
    wire        share_low;
    wire        wdog_low;
    wire        rst_int;
    wire [1:0]  ov_w;
    wire [1:0]  uv_w;
    wire [1:0]  oc_w;
    wire [1:0]  on_cmd;
    wire [1:0]  on_rise;
    wire        clear_wr;
    integer     c;

    // Status bit index of a channel field
    function integer st_bit;
        input integer chan;
        input integer field;
        begin
            st_bit = chan * `CFWM_ST_CH1 + field;
        end
    endfunction

    // Write strobe decode for one address
    function wr_hit;
        input [7:0] addr;
        begin
            wr_hit = reg_wr && (reg_addr == addr);
        end
    endfunction

    // ***************************************************************
    // Pin conditioning
    // ***************************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_line
            cfwm_deglitch #(
                .LEN (`CFWM_DEGLITCH_CYC)
            ) u_line (
                .mclk  (mclk),
                .reset (rst_int),
                .pin_n (shared_fault_line_n_in[g]),
                .low_r (line_low[g])
            );
        end
    endgenerate

    cfwm_deglitch #(
        .LEN (`CFWM_RESET_CYC)
    ) u_wdog (
        .mclk  (mclk),
        .reset (reset),
        .pin_n (watchdog_reset_in_n),
        .low_r (wdog_low)
    );

    cfwm_deglitch #(
        .LEN (`CFWM_SHARE_CYC)
    ) u_share (
        .mclk  (mclk),
        .reset (rst_int),
        .pin_n (share_clk_in),
        .low_r (share_low)
    );

    // Held low long enough: all but the watchdog filter sits in reset
    assign rst_int    = reset | wdog_low;
    assign por_active = wdog_low;

    // ***************************************************************
    // Warning comparators
    // ***************************************************************
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_cmp
            cfwm_warn_cmp u_cmp (
                .mclk      (mclk),
                .reset     (rst_int),
                .sample_v  (adc_valid && !adc_is_current
                            && (adc_chan == g)),
                .sample_i  (adc_valid && adc_is_current
                            && (adc_chan == g)),
                .adc_data  (adc_data),
                .ov_lim    (ov_lim_r[g]),
                .uv_lim    (uv_lim_r[g]),
                .oc_lim    (oc_lim_r[g]),
                .ov_warn_r (ov_w[g]),
                .uv_warn_r (uv_w[g]),
                .oc_warn_r (oc_w[g])
            );
        end
    endgenerate

    // ***************************************************************
    // Configuration registers
    // ***************************************************************
    assign clear_wr = wr_hit(`CFWM_A_CLEAR);
    assign on_cmd   = {ctrl_r[`CFWM_CTRL_ON1], ctrl_r[`CFWM_CTRL_ON0]};
    assign on_rise  = on_cmd & ~on_cmd_d_r;

    always @(posedge mclk) begin
        if (rst_int) begin
            ctrl_r                   <= `CFWM_RST_CTRL;
            ov_lim_r[0]              <= `CFWM_RST_OV_LIMIT;
            ov_lim_r[1]              <= `CFWM_RST_OV_LIMIT;
            uv_lim_r[0]              <= `CFWM_RST_LIMIT;
            uv_lim_r[1]              <= `CFWM_RST_LIMIT;
            oc_lim_r[0]              <= `CFWM_RST_OV_LIMIT;
            oc_lim_r[1]              <= `CFWM_RST_OV_LIMIT;
            fault_line_propagate_sel <= `CFWM_RST_SEL;
            fault_line_response_sel  <= `CFWM_RST_SEL;
            aux_fault_config_a       <= `CFWM_RST_SEL;
            aux_fault_config_b       <= `CFWM_RST_SEL;
            power_good_map           <= `CFWM_RST_PG_MAP;
            mask_r                   <= `CFWM_RST_MASK;
        end else begin
            if (wr_hit(`CFWM_A_CTRL))
                ctrl_r <= reg_wdata[7:0];
            if (wr_hit(`CFWM_A_OV_WARN0))
                ov_lim_r[0] <= reg_wdata[15:0];
            if (wr_hit(`CFWM_A_UV_WARN0))
                uv_lim_r[0] <= reg_wdata[15:0];
            if (wr_hit(`CFWM_A_OC_WARN0))
                oc_lim_r[0] <= reg_wdata[15:0];
            if (wr_hit(`CFWM_A_OV_WARN1))
                ov_lim_r[1] <= reg_wdata[15:0];
            if (wr_hit(`CFWM_A_UV_WARN1))
                uv_lim_r[1] <= reg_wdata[15:0];
            if (wr_hit(`CFWM_A_OC_WARN1))
                oc_lim_r[1] <= reg_wdata[15:0];
            if (wr_hit(`CFWM_A_PROPAGATE))
                fault_line_propagate_sel <= reg_wdata[3:0];
            if (wr_hit(`CFWM_A_RESPONSE))
                fault_line_response_sel <= reg_wdata[3:0];
            if (wr_hit(`CFWM_A_AUX_CFG_A))
                aux_fault_config_a <= reg_wdata[3:0];
            if (wr_hit(`CFWM_A_AUX_CFG_B))
                aux_fault_config_b <= reg_wdata[3:0];
            if (wr_hit(`CFWM_A_PG_MAP))
                power_good_map <= reg_wdata[1:0];
            if (wr_hit(`CFWM_A_MASK))
                mask_r <= reg_wdata[15:0] & `CFWM_ST_USED;
        end
    end

    // ***************************************************************
    // Status, interrupt and alert
    // ***************************************************************
    always @* begin
        set_vec      = 16'h0000;
        line_off_nxt = 2'b00;
        for (c = 0; c < 2; c = c + 1) begin
            line_off_nxt[c] =
                |(fault_line_response_sel[2*c +: 2] & line_low);
            set_vec[st_bit(c, `CFWM_ST_OVW)] = ov_w[c];
            set_vec[st_bit(c, `CFWM_ST_UVW)] = uv_w[c];
            set_vec[st_bit(c, `CFWM_ST_OCW)] = oc_w[c];
            set_vec[st_bit(c, `CFWM_ST_OVF)] = ov_fault_evt[c];
            set_vec[st_bit(c, `CFWM_ST_UVF)] = uv_fault_evt[c];
            set_vec[st_bit(c, `CFWM_ST_LINE)] =
                line_off_nxt[c] & ~line_off_r[c];
        end
        // New events win over a clear in the same cycle
        if (clear_wr)
            status_nxt = set_vec;
        else if (wr_hit(`CFWM_A_STATUS))
            status_nxt = (status_r & ~reg_wdata[15:0]) | set_vec;
        else
            status_nxt = status_r | set_vec;
    end

    always @(posedge mclk) begin
        if (rst_int) begin
            status_r       <= 16'h0000;
            alert_out_n_oe <= 1'b0;
        end else begin
            status_r       <= status_nxt;
            alert_out_n_oe <= |(status_nxt & mask_r);
        end
    end

    assign irq             = alert_out_n_oe;
    // Open drain: only ever drive low
    assign alert_out_n_out = 1'b0;

    // ***************************************************************
    // Sequencing gate
    // ***************************************************************
    // Shared clock low-to-high edge aligns all devices of an array
    always @(posedge mclk) begin
        if (rst_int) begin
            seq_on_r  <= 1'b0;
            share_d_r <= 1'b0;
        end else begin
            share_d_r <= share_low;
            if (!ctrl_r[`CFWM_CTRL_VSHARE])
                seq_on_r <= vin_on;
            else if (share_d_r && !share_low)
                seq_on_r <= vin_on;
        end
    end

    // ***************************************************************
    // Channel fault states and enables
    // ***************************************************************
    always @(posedge mclk) begin
        if (rst_int) begin
            faulted_off_r        <= 2'b00;
            aux_latch_r          <= 2'b00;
            line_off_r           <= 2'b00;
            on_cmd_d_r           <= 2'b00;
            converter_enable_out <= 2'b00;
        end else begin
            on_cmd_d_r <= on_cmd;
            line_off_r <= line_off_nxt;
            for (c = 0; c < 2; c = c + 1) begin
                if (ov_fault_evt[c] || uv_fault_evt[c])
                    faulted_off_r[c] <= 1'b1;
                else if (on_rise[c])
                    faulted_off_r[c] <= 1'b0;
                if ((ov_fault_evt[c] && aux_fault_config_a[c])
                    || (uv_fault_evt[c] && aux_fault_config_b[c]))
                    aux_latch_r[c] <= 1'b1;
                else if (on_rise[c] && faulted_off_r[c])
                    aux_latch_r[c] <= 1'b0;
            end
            // Warnings deliberately absent from this term
            converter_enable_out <= on_cmd & ~faulted_off_r
                                    & ~line_off_nxt
                                    & {2{seq_on_r}};
        end
    end

    always @(posedge mclk) begin
        if (rst_int) begin
            shared_fault_line_n_oe <= 2'b00;
            aux_fault_out_n_oe     <= 1'b0;
            power_good_out         <= 1'b0;
            dac_gain_high          <= 2'b00;
        end else begin
            for (c = 0; c < 2; c = c + 1)
                shared_fault_line_n_oe[c] <=
                    (faulted_off_r[0] & fault_line_propagate_sel[c])
                    | (faulted_off_r[1]
                       & fault_line_propagate_sel[2 + c]);
            aux_fault_out_n_oe <= |aux_latch_r;
            power_good_out     <= (|power_good_map)
                && ((output_good | ~power_good_map) == 2'b11);
            dac_gain_high      <= {ctrl_r[`CFWM_CTRL_GAIN1],
                                   ctrl_r[`CFWM_CTRL_GAIN0]};
        end
    end

    assign shared_fault_line_n_out = 2'b00;
    assign aux_fault_out_n_out     = 1'b0;

    // ***************************************************************
    // Read port
    // ***************************************************************
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (reg_addr)
            `CFWM_A_CTRL:      rd_nxt[7:0]  = ctrl_r;
            `CFWM_A_OV_WARN0:  rd_nxt[15:0] = ov_lim_r[0];
            `CFWM_A_UV_WARN0:  rd_nxt[15:0] = uv_lim_r[0];
            `CFWM_A_OC_WARN0:  rd_nxt[15:0] = oc_lim_r[0];
            `CFWM_A_OV_WARN1:  rd_nxt[15:0] = ov_lim_r[1];
            `CFWM_A_UV_WARN1:  rd_nxt[15:0] = uv_lim_r[1];
            `CFWM_A_OC_WARN1:  rd_nxt[15:0] = oc_lim_r[1];
            `CFWM_A_PROPAGATE: rd_nxt[3:0]  = fault_line_propagate_sel;
            `CFWM_A_RESPONSE:  rd_nxt[3:0]  = fault_line_response_sel;
            `CFWM_A_AUX_CFG_A: rd_nxt[3:0]  = aux_fault_config_a;
            `CFWM_A_AUX_CFG_B: rd_nxt[3:0]  = aux_fault_config_b;
            `CFWM_A_PG_MAP:    rd_nxt[1:0]  = power_good_map;
            `CFWM_A_STATUS:    rd_nxt[15:0] = status_r;
            `CFWM_A_MASK:      rd_nxt[15:0] = mask_r;
            `CFWM_A_STATE:     rd_nxt[11:0] = {line_low, line_off_r,
                                   aux_latch_r, faulted_off_r,
                                   converter_enable_out,
                                   seq_on_r, power_good_out};
            default:           rd_nxt = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rst_int)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
            reg_rdata <= rd_nxt;
        else
            reg_rdata <= 32'h0000_0000;
    end
endmodule // cfwm_top

// ---- logic/cfwm_defs.vh ----
// Offsets, field positions, reset values and timing counts of the fault manager
`ifndef CFWM_DEFS_VH
`define CFWM_DEFS_VH

// ***************************************************************
// Register offsets
// ***************************************************************
`define CFWM_A_CTRL        8'h00
`define CFWM_A_OV_WARN0    8'h04
`define CFWM_A_UV_WARN0    8'h08
`define CFWM_A_OC_WARN0    8'h0C
`define CFWM_A_OV_WARN1    8'h10
`define CFWM_A_UV_WARN1    8'h14
`define CFWM_A_OC_WARN1    8'h18
`define CFWM_A_PROPAGATE   8'h20
`define CFWM_A_RESPONSE    8'h24
`define CFWM_A_AUX_CFG_A   8'h28
`define CFWM_A_AUX_CFG_B   8'h2C
`define CFWM_A_PG_MAP      8'h30
`define CFWM_A_STATUS      8'h34
`define CFWM_A_MASK        8'h38
`define CFWM_A_CLEAR       8'h3C
`define CFWM_A_STATE       8'h40

// ***************************************************************
// Field positions
// ***************************************************************
`define CFWM_CTRL_ON0      0
`define CFWM_CTRL_ON1      1
`define CFWM_CTRL_VSHARE   2
`define CFWM_CTRL_GAIN0    4
`define CFWM_CTRL_GAIN1    5
// Status: six bits per channel, channel 1 starts at bit 8
`define CFWM_ST_OVW        0
`define CFWM_ST_UVW        1
`define CFWM_ST_OCW        2
`define CFWM_ST_OVF        3
`define CFWM_ST_UVF        4
`define CFWM_ST_LINE       5
`define CFWM_ST_CH1        8
`define CFWM_ST_USED       16'h3F3F

// ***************************************************************
// Reset values
// ***************************************************************
`define CFWM_RST_CTRL      8'h00
`define CFWM_RST_LIMIT     16'h0000
`define CFWM_RST_OV_LIMIT  16'hFFFF
`define CFWM_RST_SEL       4'h0
`define CFWM_RST_MASK      16'h3F3F
`define CFWM_RST_PG_MAP    2'h3

// ***************************************************************
// Trim DAC full scale choices, millivolts
// ***************************************************************
`define CFWM_DAC_FS_LO_MV  1380
`define CFWM_DAC_FS_HI_MV  2650

// ***************************************************************
// Timing
// ***************************************************************
`define CFWM_CLK_KHZ       25000
`define CFWM_DEGLITCH_NS   10000
`define CFWM_MIN_RESET_NS  1000
`define CFWM_DEGLITCH_CYC  ((`CFWM_DEGLITCH_NS * `CFWM_CLK_KHZ + 999999) / 1000000)
`define CFWM_RESET_CYC     ((`CFWM_MIN_RESET_NS * `CFWM_CLK_KHZ + 999999) / 1000000)
`define CFWM_SHARE_CYC     1

`endif

// ---- logic/cfwm_deglitch.v ----
// Two-stage pin synchroniser followed by a low-level deglitch filter
`timescale 1ns/1ps

module cfwm_deglitch #(
    parameter LEN = 250
) (
    input  wire mclk,
    input  wire reset,
    input  wire pin_n,
    output reg  low_r
);
    reg        s1_r;
    reg        s2_r;
    reg [15:0] cnt_r;

    // ***************************************************************
    // Synchroniser, first stage read only by the second
    // ***************************************************************
    always @(posedge mclk) begin
        if (reset) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
        end else begin
            s1_r <= pin_n;
            s2_r <= s1_r;
        end
    end

    // ***************************************************************
    // Filter: output follows only after LEN stable cycles
    // ***************************************************************
    always @(posedge mclk) begin
        if (reset) begin
            cnt_r <= 16'h0000;
            low_r <= 1'b0;
        end else if (s2_r == low_r) begin
            // Disagreement with output: count towards a change
            if (cnt_r >= LEN[15:0] - 16'h0001) begin
                cnt_r <= 16'h0000;
                low_r <= ~s2_r;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end else begin
            cnt_r <= 16'h0000;
        end
    end
endmodule // cfwm_deglitch

// ---- logic/cfwm_warn_cmp.v ----
// Per-channel warning comparator on each fresh ADC result
`timescale 1ns/1ps

module cfwm_warn_cmp (
    input  wire        mclk,
    input  wire        reset,
    input  wire        sample_v,
    input  wire        sample_i,
    input  wire [15:0] adc_data,
    input  wire [15:0] ov_lim,
    input  wire [15:0] uv_lim,
    input  wire [15:0] oc_lim,
    output reg         ov_warn_r,
    output reg         uv_warn_r,
    output reg         oc_warn_r
);
    // ***************************************************************
    // Compare only when a new result arrives
    // ***************************************************************
    always @(posedge mclk) begin
        if (reset) begin
            ov_warn_r <= 1'b0;
            uv_warn_r <= 1'b0;
            oc_warn_r <= 1'b0;
        end else begin
            ov_warn_r <= sample_v && (adc_data > ov_lim);
            uv_warn_r <= sample_v && (adc_data < uv_lim);
            // Current has an upper limit only
            oc_warn_r <= sample_i && (adc_data > oc_lim);
        end
    end
endmodule // cfwm_warn_cmp

// ---- verification/cfwm_monitor.sv ----
// Concurrent checks on the fault manager top ports
`timescale 1ns/1ps

module cfwm_monitor (
    input wire       mclk,
    input wire       reset,
    input wire       reg_wr,
    input wire [1:0] ov_fault_evt,
    input wire [1:0] uv_fault_evt,
    input wire [1:0] output_good,
    input wire [1:0] shared_fault_line_n_in,
    input wire [1:0] shared_fault_line_n_out,
    input wire       aux_fault_out_n_out,
    input wire       alert_out_n_out,
    input wire       alert_out_n_oe,
    input wire [1:0] converter_enable_out,
    input wire       power_good_out,
    input wire       irq,
    input wire       por_active
);
    // ****************
    // Line low-time counters
    // ****************
    // No line is held low past 511 cycles, so no saturation
    reg [8:0] low0_r;
    reg [8:0] low1_r;

    always @(posedge mclk) begin
        low0_r <= shared_fault_line_n_in[0] ? 9'h000 : low0_r + 9'h001;
        low1_r <= shared_fault_line_n_in[1] ? 9'h000 : low1_r + 9'h001;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_irq_alert: assert property (irq == alert_out_n_oe)
        else $error("irq differs from alert drive");
    a_open_drain: assert property (!alert_out_n_out && !aux_fault_out_n_out
        && shared_fault_line_n_out == 2'h0) else $error("pin driven high");
    a_fault_off0: assert property (ov_fault_evt[0] || uv_fault_evt[0]
        |-> ##2 !converter_enable_out[0]) else $error("ch0 kept on");
    a_fault_off1: assert property (ov_fault_evt[1] || uv_fault_evt[1]
        |-> ##2 !converter_enable_out[1]) else $error("ch1 kept on");
    a_en_cause: assert property ($fell(converter_enable_out[0]) |->
        $past(ov_fault_evt[0] || uv_fault_evt[0], 2) || low0_r >= 9'h0fa
        || low1_r >= 9'h0fa || $past(reg_wr) || $past(reg_wr, 2)
        || $past(reg_wr, 3) || por_active || $past(por_active))
        else $error("ch0 disabled without fault");
    a_alert_clear: assert property ($fell(alert_out_n_oe) |-> $past(reg_wr)
        || $past(reg_wr, 2) || por_active || $past(por_active))
        else $error("alert released without host action");
    a_pg_good: assert property (power_good_out |->
        $past(output_good) != 2'h0 || $past(output_good, 2) != 2'h0)
        else $error("power good with no good output");
    a_por_off: assert property (por_active && $past(por_active) |->
        converter_enable_out == 2'h0) else $error("enable during por");
endmodule // cfwm_monitor

bind cfwm_top cfwm_monitor u_cfwm_monitor (
    .mclk(mclk), .reset(reset), .reg_wr(reg_wr),
    .ov_fault_evt(ov_fault_evt), .uv_fault_evt(uv_fault_evt),
    .output_good(output_good),
    .shared_fault_line_n_in(shared_fault_line_n_in),
    .shared_fault_line_n_out(shared_fault_line_n_out),
    .aux_fault_out_n_out(aux_fault_out_n_out),
    .alert_out_n_out(alert_out_n_out), .alert_out_n_oe(alert_out_n_oe),
    .converter_enable_out(converter_enable_out),
    .power_good_out(power_good_out), .irq(irq), .por_active(por_active)
);

// ---- verification/cfwm_peer.sv ----
// Peer power manager that pulls a shared fault line low on request
`timescale 1ns/1ps

module cfwm_peer (
    input  wire        mclk,
    input  wire        reset,
    input  wire        go,
    input  wire [15:0] len,
    output wire        pull_oe
);
    reg [15:0] left_r;

    // Open drain: only ever pulls low, released line floats to pull-up
    assign pull_oe = (left_r != 16'h0000);

    always @(posedge mclk) begin
        if (reset) begin
            left_r <= 16'h0000;
        end else if (go) begin
            left_r <= len;
        end else if (left_r != 16'h0000) begin
            left_r <= left_r - 16'h0001;
        end
    end
endmodule // cfwm_peer

// ---- verification/cfwm_top_tb.sv ----
// Self-checking bench for the fault and warning manager
`timescale 1ns/1ps
`include "cfwm_defs.vh"

module cfwm_top_tb;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, adc_valid = 1'b0;
    logic        adc_cur = 1'b0, wdog_n = 1'b1, peer_go = 1'b0;
    logic [15:0] adc_data = 16'h0000, peer_len = 16'h0000;
    logic [1:0]  ov_evt = 2'h0, good = 2'h3;
    wire  [31:0] reg_rdata;
    wire  [1:0]  line_oe, line_in, en, gain;
    wire         aux_oe, alert_oe, pg, por, peer_oe;
    int          err_count = 0, comparisons = 0, cycles = 0;

    // Wired-AND of every party's pull-down
    assign line_in = ~(line_oe | {1'b0, peer_oe});

    cfwm_top u_cfwm_top (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .adc_valid(adc_valid), .adc_chan(1'b0),
        .adc_is_current(adc_cur), .adc_data(adc_data),
        .ov_fault_evt(ov_evt), .uv_fault_evt(2'h0), .output_good(good),
        .vin_on(1'b1), .share_clk_in(1'b0), .watchdog_reset_in_n(wdog_n),
        .shared_fault_line_n_in(line_in), .shared_fault_line_n_out(),
        .shared_fault_line_n_oe(line_oe), .aux_fault_out_n_out(),
        .aux_fault_out_n_oe(aux_oe), .alert_out_n_out(),
        .alert_out_n_oe(alert_oe), .converter_enable_out(en),
        .power_good_out(pg), .dac_gain_high(gain), .irq(),
        .por_active(por));

    cfwm_peer u_cfwm_peer (.mclk(mclk), .reset(reset), .go(peer_go),
        .len(peer_len), .pull_oe(peer_oe));

    initial begin
        forever #20 mclk = ~mclk;
    end

    // ****************
    // Bus and compare helpers
    // ****************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task adc(input logic cur, input logic [15:0] d);
        @(posedge mclk);
        adc_valid <= 1'b1;
        adc_cur <= cur;
        adc_data <= d;
        @(posedge mclk);
        adc_valid <= 1'b0;
        cyc(3);
    endtask

    task pull(input logic [15:0] n);
        @(posedge mclk);
        peer_len <= n;
        peer_go <= 1'b1;
        @(posedge mclk);
        peer_go <= 1'b0;
    endtask

    // ****************
    // Scenarios
    // ****************
    task t_regs;
        rd(`CFWM_A_CTRL, 32'h0000_0000);
        rd(`CFWM_A_MASK, 32'h0000_3f3f);
        rd(`CFWM_A_PG_MAP, 32'h0000_0003);
        rd(`CFWM_A_OV_WARN0, 32'h0000_ffff);
        rd(8'h7c, 32'h0000_0000);
        $display("test regs done");
    endtask

    task t_warn;
        wr(`CFWM_A_CTRL, 32'h0000_0003);
        wr(`CFWM_A_OV_WARN0, 32'h0000_1000);
        wr(`CFWM_A_UV_WARN0, 32'h0000_0100);
        wr(`CFWM_A_OC_WARN0, 32'h0000_1000);
        adc(1'b1, 16'h0000);
        rd(`CFWM_A_STATUS, 32'h0000_0000);
        adc(1'b0, 16'h2000);
        chk({en, alert_oe}, 32'h0000_0007);
        adc(1'b0, 16'h0080);
        adc(1'b1, 16'h2000);
        rd(`CFWM_A_STATUS, 32'h0000_0007);
        wr(`CFWM_A_STATUS, 32'h0000_0001);
        rd(`CFWM_A_STATUS, 32'h0000_0006);
        wr(`CFWM_A_MASK, 32'h0000_0000);
        cyc(2);
        chk(alert_oe, 32'h0000_0000);
        wr(`CFWM_A_MASK, 32'h0000_3f3f);
        wr(`CFWM_A_CLEAR, 32'h0000_0001);
        rd(`CFWM_A_STATUS, 32'h0000_0000);
        chk({en, alert_oe}, 32'h0000_0006);
        $display("test warn done");
    endtask

    task t_fault;
        wr(`CFWM_A_PROPAGATE, 32'h0000_0002);
        wr(`CFWM_A_RESPONSE, 32'h0000_0008);
        wr(`CFWM_A_AUX_CFG_A, 32'h0000_0001);
        @(posedge mclk);
        ov_evt <= 2'h1;
        @(posedge mclk);
        ov_evt <= 2'h0;
        cyc(2);
        chk({en, line_oe, aux_oe}, 32'h0000_0015);
        cyc(262);
        chk(en, 32'h0000_0000);
        rd(`CFWM_A_STATUS, 32'h0000_2008);
        wr(`CFWM_A_CTRL, 32'h0000_0002);
        wr(`CFWM_A_CTRL, 32'h0000_0003);
        cyc(3);
        chk({line_oe, aux_oe}, 32'h0000_0000);
        cyc(262);
        chk(en, 32'h0000_0003);
        wr(`CFWM_A_CLEAR, 32'h0000_0001);
        $display("test fault done");
    endtask

    task t_ext;
        wr(`CFWM_A_RESPONSE, 32'h0000_0009);
        pull(16'h0064);
        cyc(300);
        chk(en, 32'h0000_0003);
        pull(16'h012c);
        cyc(240);
        chk(en, 32'h0000_0003);
        cyc(22);
        chk(en, 32'h0000_0002);
        rd(`CFWM_A_STATUS, 32'h0000_0020);
        cyc(275);
        chk(en, 32'h0000_0002);
        cyc(22);
        chk(en, 32'h0000_0003);
        $display("test external done");
    endtask

    task t_pg;
        // Each entry: map, good levels, expected power good
        logic [4:0] tab [4] = '{5'h0c, 5'h15, 5'h0b, 5'h06};
        for (int i = 0; i < 4; i++) begin
            good <= tab[i][2:1];
            wr(`CFWM_A_PG_MAP, {30'h0000_0000, tab[i][4:3]});
            cyc(4);
            chk(pg, {31'h0000_0000, tab[i][0]});
        end
        good <= 2'h3;
        $display("test power good done");
    endtask

    task t_gain;
        for (int g = 0; g < 4; g++) begin
            wr(`CFWM_A_CTRL, {26'h000_0000, g[1:0], 4'h3});
            cyc(2);
            chk(gain, {30'h0000_0000, g[1:0]});
        end
        $display("test gain done");
    endtask

    task t_wdog;
        @(posedge mclk);
        wdog_n <= 1'b0;
        cyc(40);
        chk({por, en}, 32'h0000_0004);
        @(posedge mclk);
        wdog_n <= 1'b1;
        cyc(60);
        rd(`CFWM_A_CTRL, 32'h0000_0000);
        chk(por, 32'h0000_0000);
        $display("test watchdog done");
    endtask

    task conclude;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Ceiling well above the roughly 1600 cycles the tests need
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_count++;
            conclude;
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        t_regs;
        t_warn;
        t_fault;
        t_ext;
        t_pg;
        t_gain;
        t_wdog;
        conclude;
    end
endmodule // cfwm_top_tb
